/* File: core/stpa_pkg.sv */
// constants and types shared by the stop-time module access sequencer
package stpa_pkg;

   // ----------------------------------------------------------------
   // register bus map (byte addresses)
   // ----------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_COUNT = 12'h004;
   localparam logic [11:0] REG_STATUS = 12'h008;
   localparam logic [11:0] REG_LAST = 12'h00C;
   localparam logic [1:0] REGION_CTRL = 2'h0;
   localparam logic [1:0] REGION_MAIN = 2'h2;
   localparam logic [1:0] REGION_PRESET = 2'h3;

   // ----------------------------------------------------------------
   // transfer descriptor layout
   // ----------------------------------------------------------------
   localparam int D_WRITE = 0;
   localparam int D_REPEAT = 1;
   localparam int D_TC = 2;
   localparam int D_INTR = 3;
   localparam int D_MC = 4;
   localparam int D_SLOT_LSB = 5;
   localparam int D_ADDR_LSB = 8;
   localparam int D_COUNT_LSB = 15;
   localparam int D_DEV_LSB = 22;
   localparam int CTRL_CLR_PERR = 0;

   // ----------------------------------------------------------------
   // sizes, limits and status codes
   // ----------------------------------------------------------------
   localparam int TABLE_DEPTH = 128;
   localparam int DEV_DEPTH = 256;
   localparam int STOP_LIMIT = 64;
   localparam logic [2:0] SLOT_MIN = 3'h1;
   localparam logic [6:0] COUNT_MIN = 7'h01;
   localparam logic [2:0] ST_OK = 3'h0;
   localparam logic [2:0] ST_BUS_ERR = 3'h1;
   localparam logic [2:0] ST_NO_MODULE = 3'h3;
   localparam logic [2:0] ST_EXCESS = 3'h7;

   // ----------------------------------------------------------------
   // reset values and timing
   // ----------------------------------------------------------------
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
   localparam int CLK_PERIOD_NS = 25;
   localparam int ACK_TIMEOUT_NS = 10000;
   localparam int ACK_TIMEOUT_CYC = ACK_TIMEOUT_NS / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      S_IDLE, S_FETCH, S_CHECK, S_BYTE, S_WAIT, S_RELEASE, S_STORE, S_REPORT
   } stpa_state_e;

endpackage

/* File: core/stpa_byte_lane.sv */
// byte select and byte merge for a 16-bit device word, upper byte first
`timescale 1ns/1ps
module stpa_byte_lane (
   // word and lane
   input wire logic [15:0] i_word,
   input wire logic i_lane,
   // byte to merge
   input wire logic [7:0] i_byte,
   // results
   output logic [7:0] o_byte,
   output logic [15:0] o_word
);

   // lane 0 is the upper byte, lane 1 the lower
   always_comb begin
      if (i_lane) begin
         o_byte = i_word[7:0];
         o_word = {i_word[15:8], i_byte};
      end else begin
         o_byte = i_word[15:8];
         o_word = {i_byte, i_word[7:0]};
      end
   end

endmodule

/* File: core/stpa_sequencer.sv */
// stop-time sequencer moving blocks between controller devices and expansion modules
`timescale 1ns/1ps
module stpa_sequencer #(
   parameter int LIMIT = stpa_pkg::STOP_LIMIT
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_reset,
   // cpu run state
   input wire logic i_cpu_stopped,
   // register port
   input wire logic [11:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_write,
   input wire logic i_read,
   output logic [31:0] o_rdata,
   // expansion bus
   output logic o_bus_req,
   output logic o_bus_write,
   output logic [2:0] o_bus_slot,
   output logic [6:0] o_bus_addr,
   output logic [7:0] o_bus_wdata,
   input wire logic i_bus_ack,
   input wire logic i_bus_error,
   input wire logic i_bus_absent,
   input wire logic [7:0] i_bus_rdata,
   // status code write-back
   output logic o_status_we,
   output logic [6:0] o_status_entry,
   output logic [2:0] o_status_code,
   // error indication
   output logic o_program_error,
   output logic o_error_lamp,
   output logic o_busy
);

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   logic [31:0] desc_mem [stpa_pkg::TABLE_DEPTH];
   logic [15:0] main_mem [stpa_pkg::DEV_DEPTH];
   logic [15:0] preset_mem [stpa_pkg::DEV_DEPTH];

   stpa_pkg::stpa_state_e state_reg;
   logic [6:0] entry_reg;
   logic [31:0] desc_reg;
   logic [6:0] byte_reg;
   logic [15:0] word_reg;
   logic [2:0] code_reg;
   logic [9:0] timer_reg;
   logic [7:0] count_reg;
   logic perr_reg;
   logic stop_d_reg;
   logic [9:0] last_reg;
   logic [10:0] sync1_reg;
   logic [10:0] sync2_reg;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   logic ack_s;
   logic err_s;
   logic absent_s;
   logic [7:0] rdata_s;
   logic d_write;
   logic d_repeat;
   logic d_tc;
   logic [2:0] d_slot;
   logic [6:0] d_addr;
   logic [6:0] d_count;
   logic [7:0] d_dev;
   logic [7:0] word_idx;
   logic [15:0] src_word;
   logic [7:0] tx_byte;
   logic [15:0] merged_word;
   logic last_byte;
   logic word_done;
   logic stop_rise;
   logic run_write;
   logic bus_ok;
   logic [7:0] next_entry;

   assign {ack_s, err_s, absent_s, rdata_s} = sync2_reg;
   assign d_write = desc_reg[stpa_pkg::D_WRITE];
   assign d_repeat = desc_reg[stpa_pkg::D_REPEAT];
   assign d_tc = desc_reg[stpa_pkg::D_TC];
   assign d_slot = desc_reg[stpa_pkg::D_SLOT_LSB +: 3];
   assign d_addr = desc_reg[stpa_pkg::D_ADDR_LSB +: 7];
   assign d_count = desc_reg[stpa_pkg::D_COUNT_LSB +: 7];
   assign d_dev = desc_reg[stpa_pkg::D_DEV_LSB +: 8];
   // one device word carries two bytes, bit or word device alike
   // without repeat a write keeps the single source word
   assign word_idx = (d_write && !d_repeat) ? d_dev : d_dev + {2'b00, byte_reg[6:1]};
   // a write always takes the main plane: current value of timer/counter
   assign src_word = main_mem[word_idx];
   assign last_byte = (byte_reg + 7'h01) == d_count;
   assign word_done = byte_reg[0] || last_byte;
   // entering stop with a nonzero count starts the run, no enabling input
   assign stop_rise = i_cpu_stopped && !stop_d_reg;
   assign run_write = i_write && (state_reg == stpa_pkg::S_IDLE);
   assign bus_ok = i_write && !i_read;
   assign next_entry = {1'b0, entry_reg} + 8'h01;

   stpa_byte_lane u_lane (
      .i_word(d_write ? src_word : word_reg),
      .i_lane(byte_reg[0]),
      .i_byte(rdata_s),
      .o_byte(tx_byte),
      .o_word(merged_word)
   );

   // ----------------------------------------------------------------
   // pin synchronisers for the module reply
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= {i_bus_ack, i_bus_error, i_bus_absent, i_bus_rdata};
         sync2_reg <= sync1_reg;
      end
   end

   // stop level history for edge detection
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         stop_d_reg <= 1'b0;
      end else begin
         stop_d_reg <= i_cpu_stopped;
      end
   end

   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------
   // descriptor table, loaded only while idle
   always_ff @(posedge i_clock) begin
      if (bus_ok && run_write && i_addr[11:10] == stpa_pkg::REGION_CTRL && i_addr[9]) begin
         desc_mem[i_addr[8:2]] <= i_wdata;
      end
   end

   // number of transfers in the program
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         count_reg <= stpa_pkg::COUNT_RESET;
      end else if (bus_ok && run_write && i_addr == stpa_pkg::REG_COUNT) begin
         count_reg <= i_wdata[7:0];
      end
   end

   // main plane: data words, relay groups and timer/counter current values
   always_ff @(posedge i_clock) begin
      if (state_reg == stpa_pkg::S_STORE && !d_write && !d_tc && word_done) begin
         main_mem[word_idx] <= word_reg; // byte merged at ack, line since released
      end else if (bus_ok && run_write && i_addr[11:10] == stpa_pkg::REGION_MAIN) begin
         main_mem[i_addr[9:2]] <= i_wdata[15:0];
      end
   end

   // preset plane of timers and counters
   always_ff @(posedge i_clock) begin
      if (state_reg == stpa_pkg::S_STORE && !d_write && d_tc && word_done) begin
         preset_mem[word_idx] <= word_reg; // read lands in the preset
      end else if (bus_ok && run_write && i_addr[11:10] == stpa_pkg::REGION_PRESET) begin
         preset_mem[i_addr[9:2]] <= i_wdata[15:0];
      end
   end

   // program error flag; a new error wins over a clear in the same cycle
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         perr_reg <= 1'b0;
      end else if (state_reg == stpa_pkg::S_CHECK && (desc_reg[stpa_pkg::D_INTR] ||
                   d_count < stpa_pkg::COUNT_MIN)) begin
         perr_reg <= 1'b1; // interrupt routine use or count below COUNT_MIN
      end else if (bus_ok && i_addr == stpa_pkg::REG_CTRL && i_wdata[stpa_pkg::CTRL_CLR_PERR]) begin
         perr_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // register reads
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         o_rdata <= stpa_pkg::RDATA_RESET;
      end else if (i_read) begin
         unique case (i_addr[11:10])
            stpa_pkg::REGION_MAIN: o_rdata <= {16'h0000, main_mem[i_addr[9:2]]};
            stpa_pkg::REGION_PRESET: o_rdata <= {16'h0000, preset_mem[i_addr[9:2]]};
            stpa_pkg::REGION_CTRL: begin
               if (i_addr[9]) begin
                  o_rdata <= desc_mem[i_addr[8:2]];
               end else if (i_addr == stpa_pkg::REG_COUNT) begin
                  o_rdata <= {24'h000000, count_reg};
               end else if (i_addr == stpa_pkg::REG_STATUS) begin
                  o_rdata <= {16'h0000, 1'b0, entry_reg, 6'h00, perr_reg, o_busy};
               end else if (i_addr == stpa_pkg::REG_LAST) begin
                  o_rdata <= {22'h000000, last_reg};
               end else begin
                  o_rdata <= stpa_pkg::RDATA_RESET;
               end
            end
            default: o_rdata <= stpa_pkg::RDATA_RESET;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // transfer sequencer, one transfer at a time in table order
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         state_reg <= stpa_pkg::S_IDLE;
         entry_reg <= '0;
         desc_reg <= '0;
         byte_reg <= '0;
         word_reg <= '0;
         code_reg <= stpa_pkg::ST_OK;
         timer_reg <= '0;
      end else begin
         unique case (state_reg)
            stpa_pkg::S_IDLE: begin
               if (stop_rise && count_reg != 8'h00) begin
                  entry_reg <= '0;
                  state_reg <= stpa_pkg::S_FETCH;
               end
            end
            stpa_pkg::S_FETCH: begin
               // master-control bit is carried but never consulted
               desc_reg <= desc_mem[entry_reg];
               state_reg <= stpa_pkg::S_CHECK;
            end
            stpa_pkg::S_CHECK: begin
               byte_reg <= '0;
               word_reg <= '0;
               timer_reg <= '0;
               if ({1'b0, entry_reg} >= 8'(LIMIT)) begin
                  code_reg <= stpa_pkg::ST_EXCESS; // beyond the limit
                  state_reg <= stpa_pkg::S_REPORT;
               end else if (desc_reg[stpa_pkg::D_INTR] || d_count < stpa_pkg::COUNT_MIN) begin
                  // skipped without status; count field caps at 127
                  if (next_entry >= count_reg) begin
                     state_reg <= stpa_pkg::S_IDLE;
                  end else begin
                     entry_reg <= next_entry[6:0];
                     state_reg <= stpa_pkg::S_FETCH;
                  end
               end else if (d_slot < stpa_pkg::SLOT_MIN) begin
                  code_reg <= stpa_pkg::ST_NO_MODULE; // slot 1 to 7 only
                  state_reg <= stpa_pkg::S_REPORT;
               end else begin
                  state_reg <= stpa_pkg::S_BYTE;
               end
            end
            stpa_pkg::S_BYTE: begin
               timer_reg <= '0;
               state_reg <= stpa_pkg::S_WAIT;
            end
            stpa_pkg::S_WAIT: begin
               if (ack_s) begin
                  // reply classification
                  if (absent_s) begin
                     code_reg <= stpa_pkg::ST_NO_MODULE;
                  end else if (err_s) begin
                     code_reg <= stpa_pkg::ST_BUS_ERR;
                  end else begin
                     code_reg <= stpa_pkg::ST_OK;
                     word_reg <= d_write ? word_reg : merged_word;
                  end
                  state_reg <= stpa_pkg::S_RELEASE;
               end else if (timer_reg == 10'(stpa_pkg::ACK_TIMEOUT_CYC)) begin
                  code_reg <= stpa_pkg::ST_NO_MODULE;
                  state_reg <= stpa_pkg::S_RELEASE;
               end else begin
                  timer_reg <= timer_reg + 10'h001;
               end
            end
            stpa_pkg::S_RELEASE: begin
               if (!ack_s) begin
                  state_reg <= (code_reg == stpa_pkg::ST_OK) ? stpa_pkg::S_STORE :
                               stpa_pkg::S_REPORT;
               end
            end
            stpa_pkg::S_STORE: begin
               byte_reg <= byte_reg + 7'h01;
               if (word_done) begin
                  word_reg <= '0;
               end
               state_reg <= last_byte ? stpa_pkg::S_REPORT : stpa_pkg::S_BYTE;
            end
            stpa_pkg::S_REPORT: begin
               if (next_entry >= count_reg) begin
                  state_reg <= stpa_pkg::S_IDLE;
               end else begin
                  entry_reg <= next_entry[6:0];
                  state_reg <= stpa_pkg::S_FETCH;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // expansion bus request, four-phase handshake
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         o_bus_req <= 1'b0;
         o_bus_write <= 1'b0;
         o_bus_slot <= '0;
         o_bus_addr <= '0;
         o_bus_wdata <= '0;
      end else if (state_reg == stpa_pkg::S_BYTE) begin
         o_bus_req <= 1'b1;
         o_bus_write <= d_write;
         o_bus_slot <= d_slot;
         // consecutive module addresses from the start, 0 to 127
         o_bus_addr <= d_addr + byte_reg;
         o_bus_wdata <= d_write ? tx_byte : 8'h00; // outgoing byte
      end else if (state_reg == stpa_pkg::S_WAIT && (ack_s ||
                   timer_reg == 10'(stpa_pkg::ACK_TIMEOUT_CYC))) begin
         o_bus_req <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // status write-back and indications
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         o_status_we <= 1'b0;
         o_status_entry <= '0;
         o_status_code <= stpa_pkg::ST_OK;
         last_reg <= '0;
      end else begin
         o_status_we <= (state_reg == stpa_pkg::S_REPORT);
         if (state_reg == stpa_pkg::S_REPORT) begin
            o_status_entry <= entry_reg;
            o_status_code <= code_reg;
            last_reg <= {code_reg, entry_reg};
         end
      end
   end

   // program error lamp and busy follow their state
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         o_program_error <= 1'b0;
         o_error_lamp <= 1'b0;
         o_busy <= 1'b0;
      end else begin
         o_program_error <= perr_reg;
         o_error_lamp <= perr_reg;
         o_busy <= (state_reg != stpa_pkg::S_IDLE) || stop_rise;
      end
   end

endmodule

/* File: tb/stpa_sequencer_properties.sv */
// port checks for the stop-time sequencer
`timescale 1ns/1ps
module stpa_sequencer_properties #(
   parameter int LIMIT = 64
) (
   // clock, reset and run state
   input wire logic i_clock,
   input wire logic i_reset,
   input wire logic i_cpu_stopped,
   // expansion bus
   input wire logic i_bus_ack,
   input wire logic o_bus_req,
   input wire logic o_bus_write,
   input wire logic [2:0] o_bus_slot,
   input wire logic [6:0] o_bus_addr,
   input wire logic [7:0] o_bus_wdata,
   // reports and errors
   input wire logic o_status_we,
   input wire logic [6:0] o_status_entry,
   input wire logic [2:0] o_status_code,
   input wire logic o_program_error,
   input wire logic o_error_lamp,
   input wire logic o_busy
);
   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_reset);
   req_fields_a:
      assert property (o_bus_req && $past(o_bus_req) |-> $stable({o_bus_write, o_bus_slot,
         o_bus_addr, o_bus_wdata})) else $error("bus fields moved under request");
   req_hold_a:
      assert property ($rose(o_bus_req) |-> o_bus_req[*3]) else $error("request too short");
   req_ack_a:
      assert property ($fell(o_bus_req) |-> $past(i_bus_ack) && $past(i_bus_ack, 2))
         else $error("request dropped without reply");
   idle_quiet_a:
      assert property (!o_busy |-> !o_bus_req) else $error("bus request while idle");
   status_code_a:
      assert property (o_status_we |-> o_status_code inside {3'h0, 3'h1, 3'h3, 3'h7})
         else $error("unknown status code");
   excess_entry_a:
      assert property (o_status_we && o_status_code == 3'h7 |-> int'(o_status_entry) >= LIMIT)
         else $error("code 7 below the limit");
   excess_code_a:
      assert property (o_status_we && int'(o_status_entry) >= LIMIT |-> o_status_code == 3'h7)
         else $error("entry past limit not refused");
   slot_range_a:
      assert property (o_bus_req |-> o_bus_slot != 3'h0) else $error("slot 0 on bus");
   lamp_match_a:
      assert property (o_error_lamp == o_program_error) else $error("lamp differs from flag");
   stop_start_a:
      assert property ($rose(o_busy) |-> i_cpu_stopped) else $error("run without stop");
   cover property (o_status_we && o_status_code == 3'h7);
   cover property (o_status_we && o_status_code == 3'h1);
   cover property (o_bus_req && o_bus_write);
endmodule

bind stpa_sequencer stpa_sequencer_properties #(.LIMIT(LIMIT)) u_props (.i_clock, .i_reset,
   .i_cpu_stopped, .i_bus_ack, .o_bus_req, .o_bus_write, .o_bus_slot, .o_bus_addr,
   .o_bus_wdata, .o_status_we, .o_status_entry, .o_status_code, .o_program_error,
   .o_error_lamp, .o_busy);

/* File: tb/stpa_module_model.sv */
// expansion modules in slots 1 to 7, reply delay grows with slot
`timescale 1ns/1ps
module stpa_module_model (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_reset,
   // request side
   input wire logic i_req,
   input wire logic i_write,
   input wire logic [2:0] i_slot,
   input wire logic [6:0] i_addr,
   input wire logic [7:0] i_wdata,
   // faults commanded by the bench, 0 for none
   input wire logic [2:0] i_err_slot,
   input wire logic [2:0] i_absent_slot,
   // reply side
   output logic o_ack,
   output logic o_error,
   output logic o_absent,
   output logic [7:0] o_rdata
);
   logic [7:0] mem [8][128];
   int cnt;
   int reqs;
   // module memory seeded with a slot and address pattern
   initial begin
      for (int s = 0; s < 8; s++)
         for (int a = 0; a < 128; a++)
            mem[s][a] = 8'(a ^ (s * 16));
   end
   // reply is set up a cycle before ack and held until the request drops
   always @(posedge i_clock) begin
      if (i_reset) begin
         o_ack <= 1'b0;
         o_error <= 1'b0;
         o_absent <= 1'b0;
         o_rdata <= 8'h5A;
         cnt <= 0;
         reqs <= 0;
      end else if (o_ack) begin
         if (!i_req) begin
            o_ack <= 1'b0;
            o_error <= 1'b0;
            o_absent <= 1'b0;
            o_rdata <= ~o_rdata;
            cnt <= 0;
         end
      end else if (i_req) begin
         cnt <= cnt + 1;
         if (cnt == int'(i_slot)) begin
            o_error <= (i_slot == i_err_slot);
            o_absent <= (i_slot == i_absent_slot);
            o_rdata <= mem[i_slot][i_addr];
            reqs <= reqs + 1;
            if (i_write && i_slot != i_err_slot && i_slot != i_absent_slot)
               mem[i_slot][i_addr] <= i_wdata;
         end
         if (cnt == int'(i_slot) + 1)
            o_ack <= 1'b1;
      end else begin
         o_rdata <= o_rdata + 8'h3B; // released line keeps moving
      end
   end
endmodule

/* File: tb/tb.sv */
// self-checking bench for the stop-time sequencer
`timescale 1ns/1ps
module tb;
   localparam int LIM = 3;
   logic i_clock, i_reset, i_cpu_stopped, i_write, i_read, i_bus_ack, i_bus_error;
   logic i_bus_absent, o_bus_req, o_bus_write, o_status_we, o_program_error;
   logic o_error_lamp, o_busy;
   logic [11:0] i_addr;
   logic [31:0] i_wdata, o_rdata, rv;
   logic [2:0] o_bus_slot, o_status_code, err_slot, abs_slot;
   logic [6:0] o_bus_addr, o_status_entry;
   logic [7:0] o_bus_wdata, i_bus_rdata;
   logic [2:0] codes [128];
   int nrep, miscompares, checks_done;

   stpa_sequencer #(.LIMIT(LIM)) u_dut (.i_clock, .i_reset, .i_cpu_stopped, .i_addr,
      .i_wdata, .i_write, .i_read, .o_rdata, .o_bus_req, .o_bus_write, .o_bus_slot,
      .o_bus_addr, .o_bus_wdata, .i_bus_ack, .i_bus_error, .i_bus_absent, .i_bus_rdata,
      .o_status_we, .o_status_entry, .o_status_code, .o_program_error, .o_error_lamp,
      .o_busy);
   stpa_module_model u_model (.i_clock, .i_reset, .i_req(o_bus_req), .i_write(o_bus_write),
      .i_slot(o_bus_slot), .i_addr(o_bus_addr), .i_wdata(o_bus_wdata), .i_err_slot(err_slot),
      .i_absent_slot(abs_slot), .o_ack(i_bus_ack), .o_error(i_bus_error),
      .o_absent(i_bus_absent), .o_rdata(i_bus_rdata));

   // ---------------------------------------------------------------
   // clock, report capture and shared tasks
   // ---------------------------------------------------------------
   initial begin
      i_clock = 1'b0;
      forever #12.5 i_clock = ~i_clock;
   end
   // collect status reports by entry
   always @(posedge i_clock) begin
      if (o_status_we === 1'b1) begin
         codes[o_status_entry] <= o_status_code;
         nrep <= nrep + 1;
      end
   end
   function automatic logic [7:0] mb(input int s, input int a);
      return 8'(a ^ (s * 16));
   endfunction
   function automatic logic [31:0] desc(input logic [4:0] fl, input logic [2:0] s,
      input logic [6:0] a, input logic [6:0] n, input logic [7:0] dv);
      return {2'h0, dv, n, a, s, fl};
   endfunction
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge i_clock);
      i_addr <= a;
      i_wdata <= d;
      i_write <= 1'b1;
      @(posedge i_clock);
      i_write <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      @(posedge i_clock);
      i_addr <= a;
      i_read <= 1'b1;
      @(posedge i_clock);
      i_read <= 1'b0;
      #1 d = o_rdata;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // load the count, raise stop, wait for the sequencer to go idle
   task automatic run(input int n);
      int t;
      foreach (codes[k]) codes[k] = 3'h2;
      wr(stpa_pkg::REG_COUNT, 32'(n));
      nrep = 0;
      t = 0;
      @(posedge i_clock);
      i_cpu_stopped <= 1'b1;
      @(posedge i_clock);
      while (o_busy !== 1'b1 && t < 20) begin
         @(posedge i_clock);
         t++;
      end
      while (o_busy === 1'b1 && t < 20000) begin
         @(posedge i_clock);
         t++;
      end
      i_cpu_stopped <= 1'b0;
      cmp(32'(t < 20000), 32'h1);
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_read;
      wr(12'h200, desc(5'h10, 3'h1, 7'h7E, 7'h03, 8'h04));
      wr(12'h204, desc(5'h04, 3'h2, 7'h00, 7'h02, 8'h06));
      wr(12'h818, 32'h0000_1111);
      run(2);
      cmp(32'(nrep), 32'h2);
      cmp({codes[0], codes[1]}, {stpa_pkg::ST_OK, stpa_pkg::ST_OK});
      rd(12'h810, rv);
      cmp(rv, {16'h0, mb(1, 126), mb(1, 127)});
      rd(12'h814, rv);
      cmp(rv, {16'h0, mb(1, 0), 8'h00});
      rd(12'hC18, rv);
      cmp(rv, {16'h0, mb(2, 0), mb(2, 1)});
      rd(12'h818, rv);
      cmp(rv, 32'h0000_1111);
   endtask
   task automatic t_write;
      wr(12'h820, 32'h0000_A1B2);
      wr(12'h824, 32'h0000_C3D4);
      wr(12'hC20, 32'h0000_5555);
      wr(12'h200, desc(5'h03, 3'h3, 7'h0A, 7'h03, 8'h08));
      wr(12'h204, desc(5'h01, 3'h4, 7'h14, 7'h03, 8'h09));
      wr(12'h208, desc(5'h07, 3'h5, 7'h7F, 7'h02, 8'h08));
      run(3);
      cmp({codes[0], codes[1], codes[2]}, 32'h0);
      cmp({u_model.mem[3][10], u_model.mem[3][11], u_model.mem[3][12]}, 32'hA1B2C3);
      cmp({u_model.mem[4][20], u_model.mem[4][21], u_model.mem[4][22]}, 32'hC3D4C3);
      cmp({u_model.mem[5][127], u_model.mem[5][0]}, 32'hA1B2);
   endtask
   task automatic t_faults;
      err_slot <= 3'h6;
      abs_slot <= 3'h7;
      wr(12'h200, desc(5'h00, 3'h0, 7'h00, 7'h01, 8'h10));
      wr(12'h204, desc(5'h00, 3'h7, 7'h00, 7'h01, 8'h10));
      wr(12'h208, desc(5'h00, 3'h6, 7'h00, 7'h01, 8'h10));
      run(3);
      cmp({codes[0], codes[1], codes[2]}, {3'h3, 3'h3, 3'h1});
      cmp(32'(o_program_error), 32'h0);
      wr(12'h200, desc(5'h08, 3'h1, 7'h00, 7'h01, 8'h10));
      wr(12'h204, desc(5'h00, 3'h1, 7'h00, 7'h00, 8'h10));
      run(2);
      cmp(32'(nrep), 32'h0);
      rd(stpa_pkg::REG_STATUS, rv);
      cmp(32'(rv[1]), 32'h1);
      cmp(32'(o_error_lamp), 32'h1);
      wr(stpa_pkg::REG_CTRL, 32'h0000_0001);
      rd(stpa_pkg::REG_STATUS, rv);
      cmp(32'(rv[1]), 32'h0);
      rd(12'h100, rv);
      cmp(rv, 32'h0);
      err_slot <= 3'h0;
      abs_slot <= 3'h0;
   endtask
   task automatic t_limit;
      int r0;
      for (int k = 0; k < 5; k++)
         wr(12'(12'h200 + 4 * k), desc(5'h00, 3'h1, 7'(k), 7'h01, 8'(20 + k)));
      r0 = u_model.reqs;
      run(5);
      cmp(32'(u_model.reqs - r0), 32'(LIM));
      cmp({codes[0], codes[1], codes[2], codes[3], codes[4]}, 32'h0000_003F);
      rd(stpa_pkg::REG_LAST, rv);
      cmp(rv, {22'h0, stpa_pkg::ST_EXCESS, 7'h04});
   endtask

   // ---------------------------------------------------------------
   // verdict, watchdog and main sequence
   // ---------------------------------------------------------------
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      #1500000;
      miscompares++;
      tally_and_finish;
   end
   initial begin
      i_reset = 1'b1;
      i_cpu_stopped = 1'b0;
      i_write = 1'b0;
      i_read = 1'b0;
      i_addr = 12'h000;
      i_wdata = 32'h0;
      err_slot = 3'h0;
      abs_slot = 3'h0;
      nrep = 0;
      repeat (2) @(posedge i_clock);
      i_reset <= 1'b0;
      t_read;
      t_write;
      t_faults;
      t_limit;
      tally_and_finish;
   end
endmodule
